// ### core/gss_pkg.sv
// shared constants for the gated serial-in parallel-out shifter
package gss_pkg;

  // number of stages in the shift chain
  localparam int STAGE_COUNT = 8;
  // level every stage takes on clear or reset
  localparam logic STAGE_CLEAR_BIT = 1'h0;
  // index of the stage that captures the gated serial input
  localparam int FIRST_STAGE = 0;
  // level assumed on the shift clock pin during reset
  localparam logic SHIFT_CLK_IDLE = 1'h1;

endpackage : gss_pkg

// ### core/gss_rise_detect.sv
// rising-edge detector for the shift clock pin
`timescale 1ns/1ps
module gss_rise_detect
  import gss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic level,
  output logic rise
);

  logic prev;
  logic next_prev;

  // the pin is synchronous to ref_clk, so one stage of history suffices
  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= SHIFT_CLK_IDLE;
    end else begin
      prev <= next_prev;
    end
  end

  // idle-high history means a pin held high through reset gives no edge
  assign rise = level & ~prev;

endmodule : gss_rise_detect

// ### core/gss_shifter.sv
// eight-stage shifter with and-gated serial input and direct clear
`timescale 1ns/1ps
module gss_shifter
  import gss_pkg::*;
#(
  parameter int STAGES = STAGE_COUNT
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic gate_in_a,
  input wire logic gate_in_b,
  input wire logic stage_wipe_n,
  output logic [STAGES-1:0] stage_q
);

  ////////////////////////////////////////////////////////////////////////////
  // shift clock edge

  logic shift_rise;

  gss_rise_detect u_rise (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .level(shift_clk),
    .rise(shift_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shift chain

  // value every stage takes on clear or reset
  localparam logic [STAGES-1:0] CLEAR_WORD = {STAGES{STAGE_CLEAR_BIT}};

  logic serial_bit;
  logic [STAGES-1:0] next_stage_q;

  // and-gate of the two serial inputs
  assign serial_bit = gate_in_a & gate_in_b;

  always_comb begin
    next_stage_q = stage_q;
    if (shift_rise) begin
      next_stage_q = {stage_q[STAGES-2:FIRST_STAGE], serial_bit};
    end
  end

  // clear acts without the clock and wins over any edge; a shift edge
  // seen while clear is low is dropped, not held over to release
  always_ff @(posedge ref_clk or posedge sys_rst or negedge stage_wipe_n) begin
    if (sys_rst) begin
      stage_q <= CLEAR_WORD;
    end else if (!stage_wipe_n) begin
      stage_q <= CLEAR_WORD;
    end else begin
      stage_q <= next_stage_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_wipe_forces_low: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !stage_wipe_n |-> stage_q == CLEAR_WORD)
    else $error("stages not low while clear asserted");

  a_gate_low_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shift_rise && stage_wipe_n && !(gate_in_a && gate_in_b)
    |=> stage_q[FIRST_STAGE] == STAGE_CLEAR_BIT)
    else $error("first stage not low with a gate input low");

  a_gate_passes_other: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shift_rise && stage_wipe_n && gate_in_a
    |=> !stage_wipe_n || stage_q[FIRST_STAGE] == $past(gate_in_b))
    else $error("first stage did not follow the enabled gate input");

  // the gate inputs are interchangeable, so check the mirror case too
  a_gate_b_enables: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shift_rise && stage_wipe_n && gate_in_b
    |=> !stage_wipe_n || stage_q[FIRST_STAGE] == $past(gate_in_a))
    else $error("first stage did not follow gate input a");

  a_chain_moves_one: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shift_rise && stage_wipe_n
    |=> !stage_wipe_n
        || stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]))
    else $error("chain did not move by exactly one stage");

  a_hold_no_edge: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !shift_rise && stage_wipe_n |=> !stage_wipe_n || $stable(stage_q))
    else $error("stages changed without a clock edge");

  a_fall_no_shift: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $fell(shift_clk) && stage_wipe_n
    |=> !stage_wipe_n || $stable(stage_q))
    else $error("stages changed on a falling clock edge");

  // an edge is only taken after the pin was seen low on the sample before
  a_rise_needs_low: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shift_rise |-> shift_clk && !$past(shift_clk))
    else $error("edge taken without a low-to-high clock change");

  // a blocked edge must leave the chain empty even if clear lifts next
  a_wipe_beats_edge: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shift_rise && !stage_wipe_n |=> stage_q == CLEAR_WORD)
    else $error("clock edge took effect during clear");

  c_shift_one: cover property (@(posedge ref_clk) disable iff (sys_rst)
    shift_rise && stage_wipe_n && gate_in_a && gate_in_b);

  c_full_ones: cover property (@(posedge ref_clk) disable iff (sys_rst)
    stage_q == '1);

  c_wipe_after_data: cover property (@(posedge ref_clk)
    disable iff (sys_rst)
    stage_q != '0 ##1 !stage_wipe_n);

  c_edge_in_wipe: cover property (@(posedge ref_clk) disable iff (sys_rst)
    shift_rise && !stage_wipe_n);

  c_one_gate_high: cover property (@(posedge ref_clk) disable iff (sys_rst)
    shift_rise && stage_wipe_n && gate_in_a && !gate_in_b);

endmodule : gss_shifter

// ### sim/gss_far.sv
// far-side logic that drives the shift clock and gate inputs
`timescale 1ns/1ps
module gss_far (
  input wire logic ref_clk,
  input wire logic req,
  input wire logic a_in,
  input wire logic b_in,
  output logic shift_clk,
  output logic gate_in_a,
  output logic gate_in_b
);
  initial begin
    shift_clk = 1'h0;
    gate_in_a = 1'h0;
    gate_in_b = 1'h0;
  end
  always @(posedge ref_clk) begin
    shift_clk <= req;
    gate_in_a <= a_in;
    gate_in_b <= b_in;
  end
endmodule : gss_far

// ### sim/tb.sv
// self-checking bench for the gated shifter
`timescale 1ns/1ps
module tb;
  import gss_pkg::*;
  logic ref_clk = 1'h0, sys_rst = 1'h1, wipe_n = 1'h1, w;
  logic req = 1'h0, a_in = 1'h0, b_in = 1'h0, sclk, ga, gb;
  logic [STAGE_COUNT-1:0] stage_q, exp_q = '0;
  logic [STAGE_COUNT-1:0] notes[$];
  int fail_count = 0, checks_done = 0;
  always #50 ref_clk = ~ref_clk;
  gss_far u_far (.ref_clk(ref_clk), .req(req), .a_in(a_in), .b_in(b_in),
    .shift_clk(sclk), .gate_in_a(ga), .gate_in_b(gb));
  gss_shifter u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .shift_clk(sclk),
    .gate_in_a(ga), .gate_in_b(gb), .stage_wipe_n(wipe_n), .stage_q(stage_q));
  task chk(input logic [STAGE_COUNT-1:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED %0t stages %h want %h", $time, seen, want);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // one shift frame: gates and clear set, clock low, clock high, then the
  // far side's one-cycle lag puts the counted edge on the fourth edge
  task shift_once(input logic a, input logic b, input logic keep);
    @(posedge ref_clk);
    req <= 1'h0;
    a_in <= a;
    b_in <= b;
    wipe_n <= keep;
    if (!keep) exp_q = '0;
    notes.push_back(exp_q);
    @(posedge ref_clk);
    req <= 1'h1;
    @(posedge ref_clk);
    if (keep) exp_q = {exp_q[STAGE_COUNT-2:0], a & b};
    @(posedge ref_clk);
    notes.push_back(exp_q);
  endtask : shift_once
  always @(negedge ref_clk) begin
    while (notes.size() > 0) chk(stage_q, notes.pop_front());
  end
  initial begin
    #40000;
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h3285a0b4));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (48) begin
      w = ($urandom % 6) != 0;
      shift_once(1'($urandom), 1'($urandom), w);
    end
    $display("shift and wipe test done");
    repeat (STAGE_COUNT) shift_once(1'h1, 1'h1, 1'h1);
    $display("fill test done");
    @(posedge ref_clk);
    sys_rst <= 1'h1;
    @(posedge ref_clk);
    sys_rst <= 1'h0;
    exp_q = '0;
    shift_once(1'h1, 1'h1, 1'h1);
    shift_once(1'h1, 1'h0, 1'h0);
    shift_once(1'h1, 1'h1, 1'h1);
    $display("reset and wipe test done");
    end_of_test();
  end
endmodule : tb
